// File: bpc_defs.vh
// Contract
// - Zero-test jumps on zero, nonzero-test otherwise
// - Compare-with-zero branches leave flags unchanged
// - Compare-with-zero target forward 4 to 130 bytes; code reaches 4 to 258 bytes
// - Prefix makes one to four following instructions conditional
// - Slot one base; later slots then or else
// - Breakpoint in block always executes
// - Exceptions allowed around block; state saved on entry
// - Exception return resumes block with remaining conditions
// - Conditional ops in block; conditional branch range larger
// - Prefix itself leaves flags unchanged
// - Byte table branch adds twice unsigned byte
// - Halfword table indexes by index times two
// - Program counter base means address after instruction
`ifndef BPC_DEFS_VH
`define BPC_DEFS_VH
`define BPC_OP_NONE 3'h0
`define BPC_OP_ZTB 3'h1
`define BPC_OP_NZTB 3'h2
`define BPC_OP_PFX 3'h3
`define BPC_OP_TBB 3'h4
`define BPC_OP_TBH 3'h5
`define BPC_OP_BREAKPOINT_OP 3'h6
`define BPC_OP_OTHER 3'h7
`define BPC_COND_AL 4'hE
`define BPC_REG_SP 4'hD
`define BPC_REG_PC 4'hF
`define BPC_INSN_LEN 32'h00000004
`endif

// File: bpc_cond_eval.v
`timescale 1ns/1ps
`include "bpc_defs.vh"
module bpc_cond_eval (
   // Condition and flags
   input wire [3:0] cond,
   input wire [3:0] nzcv,
   // Result
   output reg pass
);
   wire n = nzcv[3];
   wire z = nzcv[2];
   wire c = nzcv[1];
   wire v = nzcv[0];
   reg base;
   always @* begin
      case (cond[3:1])
         3'h0: base = z;
         3'h1: base = c;
         3'h2: base = n;
         3'h3: base = v;
         3'h4: base = c & ~z;
         3'h5: base = (n == v);
         3'h6: base = ~z & (n == v);
         default: base = 1'b1;
      endcase
      // Low bit inverts, except for the never-fails code
      if (cond[3:1] == 3'h7) begin
         pass = 1'b1;
      end else begin
         pass = cond[0] ? ~base : base;
      end
   end
endmodule // bpc_cond_eval

// File: bpc_branch_predicate_control.v
`timescale 1ns/1ps
`include "bpc_defs.vh"
module bpc_branch_predicate_control (
   // Clock and reset
   input wire mclk,
   input wire nrst,
   // Decoded instruction
   input wire insn_valid,
   input wire [2:0] insn_op,
   input wire [31:0] insn_addr,
   input wire [3:0] opnd_reg,
   input wire [31:0] opnd_val,
   input wire [31:0] index_val,
   input wire [6:0] zt_offset,
   input wire [3:0] pfx_cond,
   input wire [3:0] pfx_mask,
   // Flags from execute
   input wire [3:0] nzcv,
   // Table read port
   output wire tbl_req,
   output wire [31:0] tbl_addr,
   output wire tbl_half,
   input wire tbl_ack,
   input wire [15:0] tbl_data,
   // Exception save and return
   input wire exc_entry,
   input wire exc_return,
   input wire [7:0] exc_ret_state,
   output wire [7:0] saved_state,
   // Results
   output wire busy,
   output reg exec_pass_q,
   output reg done_q,
   output reg br_take_q,
   output reg [31:0] br_target_q,
   output reg flags_wr_q,
   output reg misuse_q,
   output wire in_block
);
   localparam ST_IDLE = 2'b01;
   localparam ST_TBL = 2'b10;
   reg [1:0] st_q;
   reg [31:0] tbl_pc_q;
   reg tbl_half_q;
   reg [31:0] tbl_addr_q;
   // Block state: condition and remaining slot mask
   reg [3:0] blk_cond_q;
   reg [3:0] blk_mask_q;
   wire [3:0] slot_cond;
   wire slot_pass;
   wire [31:0] next_pc;
   wire take_insn;

   assign in_block = (blk_mask_q != 4'h0);
   assign saved_state = {blk_cond_q, blk_mask_q};
   assign busy = (st_q == ST_TBL);
   assign take_insn = insn_valid & (st_q == ST_IDLE);
   assign next_pc = insn_addr + `BPC_INSN_LEN;
   assign tbl_req = (st_q == ST_TBL);
   assign tbl_addr = tbl_addr_q;
   assign tbl_half = tbl_half_q;
   // Condition low bit already holds the current slot's then or else choice
   assign slot_cond = blk_cond_q;

   bpc_cond_eval u_eval (
      .cond(slot_cond),
      .nzcv(nzcv),
      .pass(slot_pass)
   );

   // Switch bits sit above the lowest set bit, which only marks the block end
   function [2:0] term_sel;
      input [3:0] m;
      begin
         term_sel = m[0] ? 3'h7 : m[1] ? 3'h6 : m[2] ? 3'h4 : 3'h0;
      end
   endfunction

   function illegal_in_block;
      input [2:0] op;
      begin
         illegal_in_block = (op == `BPC_OP_ZTB) | (op == `BPC_OP_NZTB) |
            (op == `BPC_OP_PFX);
      end
   endfunction

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_IDLE;
         blk_cond_q <= 4'h0;
         blk_mask_q <= 4'h0;
         tbl_pc_q <= 32'h00000000;
         tbl_half_q <= 1'b0;
         tbl_addr_q <= 32'h00000000;
         exec_pass_q <= 1'b0;
         done_q <= 1'b0;
         br_take_q <= 1'b0;
         br_target_q <= 32'h00000000;
         flags_wr_q <= 1'b0;
         misuse_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         br_take_q <= 1'b0;
         flags_wr_q <= 1'b0;
         misuse_q <= 1'b0;
         exec_pass_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (exc_return) begin
                  {blk_cond_q, blk_mask_q} <= exc_ret_state;
               end else if (exc_entry) begin
                  blk_mask_q <= blk_mask_q;
               end else if (take_insn) begin
                  done_q <= 1'b1;
                  if (in_block) begin
                     // Advance slot; empty mask ends the block
                     if (blk_mask_q[2:0] == 3'h0) begin
                        blk_mask_q <= 4'h0;
                     end else begin
                        blk_mask_q <= {blk_mask_q[2:0], 1'b0};
                        blk_cond_q[0] <= blk_mask_q[3];
                     end
                  end
                  if (in_block & illegal_in_block(insn_op)) begin
                     misuse_q <= 1'b1;
                  end else begin
                     exec_pass_q <= in_block ? (slot_pass | (insn_op == `BPC_OP_BREAKPOINT_OP))
                        : 1'b1;
                     case (insn_op)
                        `BPC_OP_ZTB, `BPC_OP_NZTB: begin
                           misuse_q <= opnd_reg[3];
                           br_target_q <= next_pc + {24'h000000, zt_offset, 1'b0};
                           br_take_q <= (opnd_val == 32'h00000000) ^
                              (insn_op == `BPC_OP_NZTB);
                        end
                        `BPC_OP_PFX: begin
                           blk_cond_q <= pfx_cond;
                           // Store switches as absolute low bits so slots only shift
                           blk_mask_q <= {pfx_mask[3:1] ^ (term_sel(pfx_mask) &
                              {3{pfx_cond[0]}}), pfx_mask[0]};
                           misuse_q <= (pfx_mask == 4'h0) |
                              ((pfx_cond == `BPC_COND_AL) &
                              ((pfx_mask[3:1] & term_sel(pfx_mask)) != 3'h0));
                        end
                        `BPC_OP_TBB, `BPC_OP_TBH: begin
                           if (!in_block | slot_pass) begin
                              done_q <= 1'b0;
                              st_q <= ST_TBL;
                              tbl_pc_q <= next_pc;
                              tbl_half_q <= (insn_op == `BPC_OP_TBH);
                              tbl_addr_q <= ((opnd_reg == `BPC_REG_PC) ? next_pc : opnd_val) +
                                 ((insn_op == `BPC_OP_TBH) ? {index_val[30:0], 1'b0}
                                 : index_val);
                           end
                           misuse_q <= (opnd_reg == `BPC_REG_SP) |
                              (in_block & (blk_mask_q[2:0] != 3'h0));
                        end
                        default: begin
                        end
                     endcase
                  end
               end
            end
            ST_TBL: begin
               if (tbl_ack) begin
                  st_q <= ST_IDLE;
                  done_q <= 1'b1;
                  exec_pass_q <= 1'b1;
                  br_take_q <= 1'b1;
                  br_target_q <= tbl_pc_q + (tbl_half_q ? {15'h0000, tbl_data, 1'b0}
                     : {23'h000000, tbl_data[7:0], 1'b0});
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
endmodule // bpc_branch_predicate_control

// File: bpc_chk.sv
`timescale 1ns/1ps
`include "bpc_defs.vh"
module bpc_chk (
   // Clock, reset and request side
   input wire mclk, nrst, insn_valid, busy, in_block, exc_entry, exc_return, tbl_ack,
   input wire [2:0] insn_op,
   input wire [3:0] opnd_reg, pfx_cond, pfx_mask,
   input wire [31:0] insn_addr, opnd_val, index_val, tbl_addr, br_target_q,
   input wire [6:0] zt_offset,
   input wire [7:0] exc_ret_state, saved_state,
   // Results
   input wire tbl_req, tbl_half, exec_pass_q, done_q, br_take_q, flags_wr_q, misuse_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   wire tk = insn_valid && !busy && !exc_return && !exc_entry;
   wire ob = tk && !in_block;
   wire zt = insn_op == `BPC_OP_ZTB || insn_op == `BPC_OP_NZTB;
   chk_no_flag_write: assert property (!flags_wr_q) else $error("flags written");
   chk_zero_take: assert property (ob && zt && !opnd_reg[3] |=> done_q && br_take_q ==
      (($past(opnd_val) == 0) == ($past(insn_op) == `BPC_OP_ZTB))) else $error("zero take");
   chk_zero_target: assert property (ob && zt && !opnd_reg[3] |=> br_take_q == 1'b0 ||
      br_target_q == $past(insn_addr) + 32'h4 + {$past(zt_offset), 1'b0}) else $error("zt target");
   chk_low_reg: assert property (tk && zt && opnd_reg[3] |=> misuse_q) else $error("high reg");
   chk_prefix_opens: assert property (ob && insn_op == `BPC_OP_PFX && pfx_mask != 0 &&
      pfx_cond != `BPC_COND_AL |=> in_block) else $error("no block");
   chk_pc_base: assert property (ob && insn_op == `BPC_OP_TBB && opnd_reg == `BPC_REG_PC |=>
      tbl_req && tbl_addr == $past(insn_addr) + 32'h4 + $past(index_val)) else $error("pc base");
   chk_half_index: assert property (ob && insn_op == `BPC_OP_TBH && opnd_reg < 4'hD |=>
      tbl_half && tbl_addr == $past(opnd_val) + {$past(index_val[30:0]), 1'b0}) else $error("half idx");
   chk_table_done: assert property (busy && tbl_ack |=> done_q && br_take_q) else $error("tbl");
   chk_breakpoint_op_runs: assert property (tk && insn_op == `BPC_OP_BREAKPOINT_OP |=> exec_pass_q) else $error("bk");
   chk_resume: assert property (exc_return |=> saved_state == $past(exc_ret_state)) else $error("ret");
   cov_zero_taken: cover property (ob && zt ##1 br_take_q);
   cov_table: cover property (busy && tbl_ack);
   cov_return: cover property (exc_return && in_block);
endmodule // bpc_chk

// File: bpc_tbl_model.sv
`timescale 1ns/1ps
module bpc_tbl_model (
   // Clock and reset
   input wire mclk, nrst,
   // Table read port
   input wire tbl_req,
   input wire [31:0] tbl_addr,
   input wire [1:0] lat,
   output reg tbl_ack,
   output reg [15:0] tbl_data
);
   reg [1:0] cnt_q;
   wire hit = tbl_req && !tbl_ack && cnt_q == lat;
   // Answers after lat wait cycles; data lines toggle while not answering
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 2'h0;
         tbl_ack <= 1'b0;
         tbl_data <= 16'h0000;
      end else begin
         tbl_ack <= hit;
         cnt_q <= (tbl_req && !tbl_ack && !hit) ? cnt_q + 2'h1 : 2'h0;
         tbl_data <= hit ? tbl_addr[15:0] ^ 16'hA5C3 : ~tbl_data;
      end
   end
endmodule // bpc_tbl_model

// File: bpc_branch_predicate_control_tb.sv
`timescale 1ns/1ps
`include "bpc_defs.vh"
module bpc_branch_predicate_control_tb;
   reg mclk = 1'b0, nrst = 1'b0, insn_valid = 1'b0, exc_entry = 1'b0, exc_return = 1'b0;
   reg [2:0] insn_op = 3'h0;
   reg [3:0] opnd_reg = 4'h0, pfx_cond = 4'h0, pfx_mask = 4'h8, nzcv = 4'h0;
   reg [31:0] insn_addr = 32'h0, opnd_val = 32'h0, index_val = 32'h0, ta;
   reg [6:0] zt_offset = 7'h00;
   reg [7:0] exc_ret_state = 8'h00;
   reg [1:0] lat = 2'h0;
   wire tbl_req, tbl_half, tbl_ack, busy, exec_pass_q, done_q, br_take_q, flags_wr_q, misuse_q;
   wire in_block;
   wire [31:0] tbl_addr, br_target_q;
   wire [15:0] tbl_data;
   wire [7:0] saved_state;
   integer mismatches = 0, checks = 0, seed = 3320, cyc = 0, rem = 0, k = 0, i, e, t, p, w;
   reg [3:0] pm = 4'h0, bc = 4'h0;
   bpc_branch_predicate_control u_bpc_branch_predicate_control (.*);
   bpc_tbl_model u_bpc_tbl_model (.*);
   task cmp(input [63:0] nm, input [31:0] exp, input [31:0] got);
      begin
         checks = checks + 1;
         if (exp !== got) begin
            mismatches = mismatches + 1;
            $display("BAD %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", checks, mismatches);
         if (mismatches == 0 && checks > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial forever #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         mismatches = mismatches + 1;
         give_verdict;
      end
   end
   initial begin
      #75 nrst = 1'b1;
      for (i = 0; i < 500; i = i + 1) begin
         @(posedge mclk);
         #1 e = $random(seed) & 7;
         if (rem > 0 && (e > 0 && e < 4 || e > 3 && e < 6 && rem > 1)) e = 7;
         nzcv = $random(seed);
         insn_addr = $random(seed) & 32'hFFFFFFFE;
         opnd_reg = $random(seed);
         if (opnd_reg == `BPC_REG_SP) opnd_reg = `BPC_REG_PC;
         if (e < 3) opnd_reg = {i % 16 == 5, opnd_reg[2:0]};
         opnd_val = ($random(seed) & 1) ? 32'h0 : $random(seed);
         index_val = $random(seed) & 32'hFF;
         zt_offset = $random(seed);
         t = $random(seed) & 3;
         pfx_cond = (t > 1) ? `BPC_COND_AL : t[3:0];
         pfx_mask = $random(seed);
         if (pfx_mask == 4'h0 || pfx_cond == `BPC_COND_AL) pfx_mask = 4'h8 >> (t & 3);
         lat = $random(seed);
         p = rem == 0 || bc == `BPC_COND_AL || (nzcv[2] ^ bc[0] ^ (k > 0 && pm[4 - k]));
         if (e == 0) begin
            exc_ret_state = saved_state;
            exc_entry = 1'b1;
            @(posedge mclk);
            #1 exc_entry = 1'b0;
            exc_return = 1'b1;
            @(posedge mclk);
            #1 exc_return = 1'b0;
            cmp("inblk", rem > 0, in_block);
         end else begin
            insn_op = e;
            insn_valid = 1'b1;
            @(posedge mclk);
            #1 insn_valid = 1'b0;
            if (e < 3 && opnd_reg[3]) cmp("misuse", 1, misuse_q);
            else begin
               for (w = 0; w < 9 && done_q !== 1'b1; w = w + 1) @(posedge mclk) #1;
               t = e < 3 ? (opnd_val == 0) ^ (e == 2) : (e == 4 || e == 5) && p;
               ta = insn_addr + 4 + 2 * zt_offset;
               if (e > 3) ta = (opnd_reg == `BPC_REG_PC ? insn_addr + 4 : opnd_val) + (index_val << (e == 5));
               if (e > 3) ta = insn_addr + 4 + 2 * (e == 5 ? ta[15:0] ^ 16'hA5C3 : ta[7:0] ^ 8'hC3);
               cmp("done", 1, done_q);
               cmp("pass", p || e == 6, exec_pass_q);
               cmp("take", t, br_take_q);
               if (t) cmp("target", ta, br_target_q);
               if (rem > 0) rem = rem - 1;
               k = k + 1;
               if (e == 3 && rem == 0) begin
                  rem = pfx_mask[0] ? 4 : pfx_mask[1] ? 3 : pfx_mask[2] ? 2 : 1;
                  pm = pfx_mask;
                  bc = pfx_cond;
                  k = 0;
               end
               cmp("inblk", rem > 0, in_block);
            end
         end
      end
      give_verdict;
   end
endmodule // bpc_branch_predicate_control_tb
bind bpc_branch_predicate_control bpc_chk u_bpc_chk (.*);
